// [dv/lgs_top_bench.sv]
// self-checking bench for the logic cell gate input select block
`timescale 1ns/1ps
`include "lgs_defs.svh"
module lgs_top_bench;
   // clock, reset and bus
   logic        clk_i = 1'b0;
   logic        reset_i = 1'b1;
   logic        wb_cyc_i = 1'b0;
   logic        wb_stb_i = 1'b0;
   logic        wb_we_i = 1'b0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   // gate path
   logic [63:0] src_i = 64'h0;
   logic        g1_o;
   logic        g2_o;
   logic        g3_o;
   int          fail_count = 0;
   int          cmp_count = 0;
   int          seed;

   always #2.5 clk_i = ~clk_i;

   lgs_top dut (.clk_i(clk_i), .reset_i(reset_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .src_i(src_i), .gate_one_out_o(g1_o),
      .gate_two_out_o(g2_o), .gate_three_out_o(g3_o));

   //////////////////////////////////////////////////////////////////////////////
   task automatic print_verdict;
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one classic cycle; request held until ack is sampled
   task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [7:0] wd,
                          output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_dat_i <= {24'h0, wd};
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (n >= 20) begin
         fail_count++;
         print_verdict;
      end
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   // or of selected forms, pair k holds true above inverted
   function automatic logic gate_exp(logic [7:0] s, logic [3:0] d, logic p);
      logic r;
      r = 1'b0;
      for (int k = 0; k < 4; k++)
         r = r | (s[2*k+1] & d[k]) | (s[2*k] & ~d[k]);
      return r ^ p;
   endfunction

   //////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [31:0] rd;
      logic [7:0]  gs [3];
      logic [5:0]  ds [4];
      logic [2:0]  pol;
      logic [3:0]  d;
      logic [31:0] st;
      seed = 32'hDEAFC0A6;
      repeat (2) @(posedge clk_i);
      reset_i <= 1'b0;
      for (int g = 0; g < 3; g++) begin
         wb_xfer(1'b0, 8'(4 * g), 8'h00, rd);
         check(rd, 32'h0);
      end
      wb_xfer(1'b1, 8'h3C, 8'hFF, rd);
      wb_xfer(1'b0, 8'h3C, 8'h00, rd);
      check(rd, 32'h0);
      for (int it = 0; it < 40; it++) begin
         // corners: empty gates inverted, all forms, data four true alone
         pol = (it == 0) ? 3'h7 : (it == 2) ? 3'h0 : 3'($random(seed));
         for (int g = 0; g < 3; g++) begin
            gs[g] = (it == 0) ? 8'h00 : (it == 1) ? 8'hFF : 8'($random(seed));
            if (it == 2)
               gs[g] = 8'h80;
            wb_xfer(1'b1, 8'(4 * g), gs[g], rd);
         end
         for (int k = 0; k < 4; k++) begin
            ds[k] = 6'($random(seed));
            wb_xfer(1'b1, `LGS_OFF_DSEL1 + 8'(4 * k), {2'b0, ds[k]}, rd);
         end
         wb_xfer(1'b1, `LGS_OFF_POL, {5'b0, pol}, rd);
         wb_xfer(1'b0, `LGS_OFF_POL, 8'h00, rd);
         check(rd, {29'h0, pol});
         for (int k = 0; k < 4; k++) begin
            wb_xfer(1'b0, `LGS_OFF_DSEL1 + 8'(4 * k), 8'h00, rd);
            check(rd, {26'h0, ds[k]});
         end
         for (int g = 0; g < 3; g++) begin
            wb_xfer(1'b0, 8'(4 * g), 8'h00, rd);
            check(rd, {24'h0, gs[g]});
         end
         src_i <= {32'($random(seed)), 32'($random(seed))};
         // four edges through sync and gate register, two spare
         repeat (6) @(posedge clk_i);
         for (int k = 0; k < 4; k++)
            d[k] = src_i[ds[k]];
         check({31'h0, g1_o}, {31'h0, gate_exp(gs[0], d, pol[0])});
         check({31'h0, g2_o}, {31'h0, gate_exp(gs[1], d, pol[1])});
         check({31'h0, g3_o}, {31'h0, gate_exp(gs[2], d, pol[2])});
         // status shows the current data values and gate results
         st = 32'(d) << `LGS_ST_DATA_LSB;
         for (int g = 0; g < 3; g++)
            st[`LGS_ST_GATE_LSB + g] = gate_exp(gs[g], d, pol[g]);
         wb_xfer(1'b0, `LGS_OFF_STATUS, 8'h00, rd);
         check(rd, st);
      end
      // write without the low byte lane leaves the register alone
      wb_sel_i <= 4'hE;
      wb_xfer(1'b1, `LGS_OFF_GATE1, ~gs[0], rd);
      wb_sel_i <= 4'hF;
      wb_xfer(1'b0, `LGS_OFF_GATE1, 8'h00, rd);
      check(rd, {24'h0, gs[0]});
      print_verdict;
   end
endmodule // lgs_top_bench

// [src/lgs_defs.svh]
// constants for the logic cell gate input select block
`ifndef LGS_DEFS_SVH
`define LGS_DEFS_SVH

// register byte offsets on the wishbone bus
`define LGS_OFF_GATE1   8'h00
`define LGS_OFF_GATE2   8'h04
`define LGS_OFF_GATE3   8'h08
`define LGS_OFF_POL     8'h0C
`define LGS_OFF_DSEL1   8'h10
`define LGS_OFF_DSEL2   8'h14
`define LGS_OFF_DSEL3   8'h18
`define LGS_OFF_DSEL4   8'h1C
`define LGS_OFF_STATUS  8'h20

// widths
`define LGS_SRC_W       6
`define LGS_NUM_GATES   3
`define LGS_NUM_DATA    4
`define LGS_ADR_W       8

// reset values (the gate selects have no defined power-on value, zero is used)
`define LGS_GSEL_RST    8'h00
`define LGS_POL_RST     3'h0
`define LGS_DSEL_RST    6'h00

// status register layout
`define LGS_ST_GATE_LSB 0
`define LGS_ST_DATA_LSB 4

`endif

// [src/lgs_gate.sv]
// one gate: or of the selected data forms, then output polarity
`timescale 1ns/1ps
module lgs_gate (
   // selection
   input  wire logic                     invert_i,
   input  wire lgs_pkg::lgs_gate_sel_type sel_i,
   // data forms, same bit order as the select register
   input  wire logic [7:0]               pair_i,
   // result
   output logic                          gate_o
);

   wire logic [7:0] sel_bits = sel_i;
   wire logic       raw_or   = |(sel_bits & pair_i);

   assign gate_o = raw_or ^ invert_i;

endmodule // lgs_gate

// [src/lgs_pkg.sv]
// types shared by the logic cell gate input select block
package lgs_pkg;

   // one gate select register: data 4 pair on top, true bit above inverted bit
   typedef struct packed {
      logic d4_true;
      logic d4_inv;
      logic d3_true;
      logic d3_inv;
      logic d2_true;
      logic d2_inv;
      logic d1_true;
      logic d1_inv;
   } lgs_gate_sel_type;

endpackage

// [src/lgs_top.sv]
// logic cell gate input select with wishbone register access
`timescale 1ns/1ps
`include "lgs_defs.svh"

//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - gate 1 ORs data forms whose bits set
// - gate 2 selects forms from its own register
// - gate 3 selects forms from a third register
// - fields data4 top to data1, true above inverted
// - all select bits read/write, cleared to zero by reset
// - gate polarity bit one inverts gate output
// - each data signal muxed by six-bit source field
module lgs_top #(
   parameter int SRC_W = `LGS_SRC_W
) (
   // clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 reset_i,
   // wishbone slave
   input  wire logic                 wb_cyc_i,
   input  wire logic                 wb_stb_i,
   input  wire logic                 wb_we_i,
   input  wire logic [7:0]           wb_adr_i,
   input  wire logic [3:0]           wb_sel_i,
   input  wire logic [31:0]          wb_dat_i,
   output logic      [31:0]          wb_dat_o,
   output logic                      wb_ack_o,
   // candidate signals for the data multiplexers
   input  wire logic [(1<<SRC_W)-1:0] src_i,
   // gate outputs toward the cell function logic
   output logic                      gate_one_out_o,
   output logic                      gate_two_out_o,
   output logic                      gate_three_out_o
);

   localparam int NG = `LGS_NUM_GATES;
   localparam int ND = `LGS_NUM_DATA;

   if (SRC_W < 1 || SRC_W > `LGS_SRC_W) begin : g_chk
      $error("lgs_top: SRC_W out of range");
   end

   //////////////////////////////////////////////////////////////////////////
   // state

   lgs_pkg::lgs_gate_sel_type gsel_q [NG];
   logic [NG-1:0]             pol_q;
   logic [SRC_W-1:0]          dsel_q [ND];
   logic [(1<<SRC_W)-1:0]     src_m_q;
   logic [(1<<SRC_W)-1:0]     src_s_q;
   logic [ND-1:0]             data_q;
   logic [NG-1:0]             gate_q;
   logic [NG-1:0]             gate_d;
   logic                      ack_q;
   logic [31:0]               dat_q;
   logic [31:0]               rd_d;

   //////////////////////////////////////////////////////////////////////////
   // bus decode

   wire logic       req     = wb_cyc_i & wb_stb_i & ~ack_q;
   wire logic       wr_en   = req & wb_we_i & wb_sel_i[0];
   wire logic [7:0] word    = {wb_adr_i[7:2], 2'b00};
   wire logic [7:0] wbyte   = wb_dat_i[7:0];

   localparam logic [7:0] GATE_OFF [NG] = '{`LGS_OFF_GATE1, `LGS_OFF_GATE2, `LGS_OFF_GATE3};
   localparam logic [7:0] DSEL_OFF [ND] =
      '{`LGS_OFF_DSEL1, `LGS_OFF_DSEL2, `LGS_OFF_DSEL3, `LGS_OFF_DSEL4};

   wire logic wr_pol = wr_en & (word == `LGS_OFF_POL);

   //////////////////////////////////////////////////////////////////////////
   // select registers and gates

   // data forms in register order: bit 2n+1 true, bit 2n inverted
   logic [7:0] pair;
   for (genvar n = 0; n < ND; n++) begin : g_pair
      assign pair[2*n+1] = data_q[n];
      assign pair[2*n]   = ~data_q[n];
   end

   for (genvar k = 0; k < NG; k++) begin : g_gate
      wire logic wr_g = wr_en & (word == GATE_OFF[k]);

      // zero stands in for the undefined power-on value
      always_ff @(posedge clk_i) begin
         if (reset_i) begin
            gsel_q[k] <= `LGS_GSEL_RST;
         end else if (wr_g) begin
            gsel_q[k] <= wbyte;
         end
      end

      lgs_gate u_gate (
         .invert_i (pol_q[k]),
         .sel_i    (gsel_q[k]),
         .pair_i   (pair),
         .gate_o   (gate_d[k])
      );
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         pol_q <= `LGS_POL_RST;
      end else if (wr_pol) begin
         pol_q <= wbyte[NG-1:0];
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // data multiplexers

   // candidates come from other clocks or pins, so two flops before use
   always_ff @(posedge clk_i) begin
      src_m_q <= src_i;
      src_s_q <= src_m_q;
   end

   for (genvar n = 0; n < ND; n++) begin : g_dsel
      wire logic wr_d = wr_en & (word == DSEL_OFF[n]);

      always_ff @(posedge clk_i) begin
         if (reset_i) begin
            dsel_q[n] <= SRC_W'(`LGS_DSEL_RST);
         end else if (wr_d) begin
            dsel_q[n] <= wbyte[SRC_W-1:0];
         end
      end

      always_ff @(posedge clk_i) begin
         if (reset_i) begin
            data_q[n] <= 1'b0;
         end else begin
            data_q[n] <= src_s_q[dsel_q[n]];
         end
      end
   end

   // gate outputs registered so the cell logic sees glitch-free levels
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         gate_q <= '0;
      end else begin
         gate_q <= gate_d;
      end
   end

   assign gate_one_out_o   = gate_q[0];
   assign gate_two_out_o   = gate_q[1];
   assign gate_three_out_o = gate_q[2];

   //////////////////////////////////////////////////////////////////////////
   // read back and acknowledge

   always_comb begin
      rd_d = '0;
      case (word)
         `LGS_OFF_GATE1:  rd_d[7:0] = gsel_q[0];
         `LGS_OFF_GATE2:  rd_d[7:0] = gsel_q[1];
         `LGS_OFF_GATE3:  rd_d[7:0] = gsel_q[2];
         `LGS_OFF_POL:    rd_d[NG-1:0] = pol_q;
         `LGS_OFF_DSEL1:  rd_d[SRC_W-1:0] = dsel_q[0];
         `LGS_OFF_DSEL2:  rd_d[SRC_W-1:0] = dsel_q[1];
         `LGS_OFF_DSEL3:  rd_d[SRC_W-1:0] = dsel_q[2];
         `LGS_OFF_DSEL4:  rd_d[SRC_W-1:0] = dsel_q[3];
         `LGS_OFF_STATUS: begin
            rd_d[`LGS_ST_GATE_LSB +: NG] = gate_q;
            rd_d[`LGS_ST_DATA_LSB +: ND] = data_q;
         end
         default:         rd_d = '0;
      endcase
   end

   // one wait state: ack follows the request by one edge, unmapped reads give zero
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         ack_q <= 1'b0;
         dat_q <= '0;
      end else begin
         ack_q <= req;
         dat_q <= req ? rd_d : dat_q;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;

   //////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   sequence wr_gate1_s;
      wr_en && word == `LGS_OFF_GATE1;
   endsequence

   sequence rd_gate1_s;
      req && !wb_we_i && word == `LGS_OFF_GATE1;
   endsequence

   // reference built field by field, so a swapped pair wiring cannot hide
   function automatic logic sel_or(lgs_pkg::lgs_gate_sel_type s, logic [ND-1:0] d);
      return (s.d4_true & d[3]) | (s.d4_inv & ~d[3])
           | (s.d3_true & d[2]) | (s.d3_inv & ~d[2])
           | (s.d2_true & d[1]) | (s.d2_inv & ~d[1])
           | (s.d1_true & d[0]) | (s.d1_inv & ~d[0]);
   endfunction

   // sampled reset guards the edge where the flops still load reset values
   gate_one_sel_a: assert property (!reset_i |=> gate_q[0] ==
      ($past(sel_or(gsel_q[0], data_q)) ^ $past(pol_q[0])))
      else $error("gate one output wrong");

   gate_two_sel_a: assert property (!reset_i |=> gate_q[1] ==
      ($past(sel_or(gsel_q[1], data_q)) ^ $past(pol_q[1])))
      else $error("gate two output wrong");

   gate_three_sel_a: assert property (!reset_i |=> gate_q[2] ==
      ($past(sel_or(gsel_q[2], data_q)) ^ $past(pol_q[2])))
      else $error("gate three output wrong");

   field_order_a: assert property (gsel_q[0] == 8'h80 && !pol_q[0]
      |=> gate_q[0] == $past(data_q[3]))
      else $error("data four true not in top bit");

   write_read_a: assert property (rd_gate1_s
      |=> wb_ack_o && wb_dat_o[7:0] == $past(gsel_q[0], 1))
      else $error("gate one select readback wrong");

   write_take_a: assert property (wr_gate1_s |=> gsel_q[0] == $past(wbyte))
      else $error("gate one select write lost");

   pol_invert_a: assert property (gsel_q[1] == 8'h00 && pol_q[1]
      |=> gate_q[1])
      else $error("empty gate with invert not one");

   mux_route_a: assert property (!reset_i |=> data_q[0] ==
      $past(src_s_q[dsel_q[0]]))
      else $error("data one source wrong");

   empty_zero_a: assert property (gsel_q[2] == 8'h00 && !pol_q[2]
      |=> !gate_q[2])
      else $error("empty gate not zero");

   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");

endmodule // lgs_top
